// ---- hdl/board_bus_controller.sv ----
// Board bus controller: address decode, local bus, DRAM timing, parallel control port
//
// Summary of operation
// - Access to 0x10000000-0x15FFFFFF times out after about 8 us, raising interrupt.
// - 0x00000000-0x0007FFFF selects the 512 KB static RAM.
// - 0x04000000-0x07FFFFFF selects the module DRAM.
// - 0x1A000000-0x1AFFFFFF selects expansion bus, halfword uncached access only.
// - 0x1C000000-0x1CFFFFFF selects on-board I/O, uncached only.
// - 0x1F000000-0x1FFFFFFF selects the 256 KB ROM.
// - I/O address bits 15:8 pick UART, parallel port, switch/LED, host interface.
// - I/O devices use data bits 7:0; big-endian bytes add offset three.
// - After reset all port lines are inputs; outputs read high.
// - Port 0, 1 and 2 bit layouts as listed.
// - Local-cycle select gives 4, 1, 2, 3 local clocks minimum.
// - Local bus clock is processor transmit clock divided by two.
// - SRAM wait select inserts 0 to 3 read wait states.
// - DRAM width select sets precharge, RAS, read and write CAS clocks.
// - Interleave disable 0 interleaves, 1 does not.
// - Page-hit disable 0 allows page hits, 1 forbids them.
// - Active-low timeout flag drops and stays low on timeout.
// - Timeout flag returns high on a low-then-high pulse of clear.
// - Interrupt gate high blocks interrupt lines 0 to 2; starts high.
// - DTR output is the inverse of the terminal-ready bit.
// - DSR status bit reads the inverse of the DSR input.
// - Presence-detect bits report DRAM size: 4, reserved, 16, 8 MB.
// - Unassigned regions end the cycle with a bus error.
// - SRAM writes never receive wait states.
// - CAS-before-RAS refresh every 13 us.
`timescale 1ns/1ps
module board_bus_controller (
   // Clock and reset
   input  wire logic                      REF_CLK,
   input  wire logic                      RST_N,
   // Processor request
   input  wire logic                      CPU_REQ,
   input  wire logic [31:0]               CPU_ADDR,
   input  wire logic                      CPU_WR,
   input  wire logic                      CPU_HALF,
   input  wire logic [7:0]                CPU_WDATA,
   output logic                           CPU_ACK,
   output logic                           CPU_BERR,
   output logic [7:0]                     CPU_RDATA,
   // Memory and local bus strobes
   output board_bus_pkg::win_sel_s        SEL,
   output logic [1:0]                     RAS_N,
   output logic                           CAS_N,
   output logic                           LB_RD_N,
   output logic                           LB_WR_N,
   output logic                           LOCAL_BUS_CLOCK,
   input  wire logic                      PROCESSOR_TRANSMIT_CLOCK,
   input  wire logic                      EXT_READY,
   // Interrupts
   input  wire logic [2:0]                IRQ_IN_N,
   output logic [2:0]                     IRQ_OUT_N,
   // Serial and module status
   output logic                           DTR_OUT,
   input  wire logic                      DSR_IN,
   input  wire logic [1:0]                MODULE_PRESENCE_DETECT
);
   import board_bus_pkg::*;

   typedef enum logic [2:0] {S_IDLE, S_SRAM, S_PRE, S_RAS, S_CAS, S_LOCAL, S_DONE, S_REF} st_e;

   typedef struct packed {
      st_e        state;
      logic [8:0] cnt;
      logic [8:0] lbcnt;
      logic [31:0] addr;
      logic       wr;
      win_e       win;
      logic       ack;
      logic       berr;
      logic [7:0] rdata;
      win_sel_s   sel;
      logic [1:0] ras_n;
      logic       cas_n;
      logic       rd_n;
      logic       wr_n;
      logic       local_bus_clock;
      logic       tclk_prev;
      logic [7:0] p0;
      logic [7:0] p1;
      logic [7:0] p2;
      logic [2:0] dir;
      logic       tof_n;
      logic       clr_prev;
      logic [2:0] irq_n;
      logic       dtr;
      logic [8:0] ref_cnt;
      logic       ref_pend;
      logic       page_open;
      logic [11:0] open_row;
      logic       open_bank;
   } st_s;

   st_s r_ff;
   st_s nxt_r;

   // Effective port values: lines not set as outputs float high
   logic [7:0] p0_eff;
   logic [7:0] p1_eff;
   logic [7:0] p2_eff;
   logic [8:0] lwid_cyc;
   logic [3:0] swait;
   dram_tim_s  dtim;
   win_e       dec_win;
   logic       bank;
   logic       lb_tick;
   logic       tclk_rise;

   // reset directions are inputs, pull-ups read as ones
   assign p0_eff = r_ff.dir[0] ? r_ff.p0 : PORT_RST;
   assign p1_eff = r_ff.dir[1] ? r_ff.p1 : PORT_RST;
   assign p2_eff = r_ff.dir[2] ? r_ff.p2 : PORT_RST;

   // local cycle minimum in local clocks
   always_comb begin
      unique case (p0_eff[LWID_LSB +: 2])
         2'h0: lwid_cyc = 9'h004;
         2'h1: lwid_cyc = 9'h001;
         2'h2: lwid_cyc = 9'h002;
         2'h3: lwid_cyc = 9'h003;
      endcase
   end

   // SRAM read wait states equal the code
   assign swait = {2'h0, p1_eff[SWAIT_LSB +: 2]};

   always_comb begin
      unique case (p1_eff[DWID_LSB +: 2])
         2'h0: dtim = '{4'h2, 4'h3, 4'h1, 4'h1};
         2'h1: dtim = '{4'h3, 4'h4, 4'h2, 4'h1};
         2'h2: dtim = '{4'h4, 4'h5, 4'h3, 4'h2};
         2'h3: dtim = '{4'h5, 4'h6, 4'h4, 4'h3};
      endcase
   end

   // Physical address decode
   always_comb begin
      dec_win = W_ERR;
      if (CPU_ADDR <= SRAM_TOP) begin
         dec_win = W_SRAM;
      end else if (CPU_ADDR[31:24] >= DRAM_LO && CPU_ADDR[31:24] <= DRAM_HI) begin
         dec_win = W_DRAM;
      end else if (CPU_ADDR[31:24] >= TO_LO && CPU_ADDR[31:24] <= TO_HI) begin
         dec_win = W_TO;
      // expansion bus, halfword only, else bus error
      end else if (CPU_ADDR[31:24] == EXT_PAGE) begin
         dec_win = CPU_HALF ? W_EXT : W_ERR;
      end else if (CPU_ADDR[31:24] == IO_PAGE) begin
         dec_win = W_IO;
      end else if (CPU_ADDR[31:24] == ROM_PAGE) begin
         dec_win = W_ROM;
      end
   end

   // interleave picks bank from low bit 3, else from address bit 23 just above the row
   assign bank = p1_eff[ILV_DIS_BIT] ? CPU_ADDR[23] : CPU_ADDR[3];

   // local clock toggles on each rising processor clock edge
   assign tclk_rise = PROCESSOR_TRANSMIT_CLOCK & ~r_ff.tclk_prev;
   assign lb_tick   = tclk_rise & ~r_ff.local_bus_clock;

   // Next-state logic for the whole controller
   always_comb begin
      logic [8:0] need;
      logic       io_dev;
      need   = 9'h000;
      io_dev = 1'b0;
      nxt_r = r_ff;
      nxt_r.ack  = 1'b0;
      nxt_r.berr = 1'b0;
      nxt_r.tclk_prev = PROCESSOR_TRANSMIT_CLOCK;
      if (tclk_rise) begin
         nxt_r.local_bus_clock = ~r_ff.local_bus_clock;
      end
      if (r_ff.ref_cnt == REFRESH_CNT - 9'h001) begin
         nxt_r.ref_cnt  = 9'h000;
         nxt_r.ref_pend = 1'b1;
      end else begin
         nxt_r.ref_cnt = r_ff.ref_cnt + 9'h001;
      end
      // clear on rising edge of clear line; set wins
      nxt_r.clr_prev = p2_eff[TCLR_BIT];
      if (p2_eff[TCLR_BIT] && !r_ff.clr_prev) begin
         nxt_r.tof_n = 1'b1;
      end
      unique case (r_ff.state)
         S_IDLE: begin
            nxt_r.cnt   = 9'h000;
            nxt_r.lbcnt = 9'h000;
            if (r_ff.ref_pend) begin
               // Refresh closes any open page first
               nxt_r.ref_pend  = 1'b0;
               nxt_r.page_open = 1'b0;
               nxt_r.ras_n     = 2'b11;
               nxt_r.cas_n     = 1'b0;
               nxt_r.state     = S_REF;
            end else if (CPU_REQ && !r_ff.ack) begin // Request still held in ack cycle
               nxt_r.addr = CPU_ADDR;
               nxt_r.wr   = CPU_WR;
               nxt_r.win  = dec_win;
               unique case (dec_win)
                  W_SRAM: begin
                     nxt_r.sel.sram = 1'b1;
                     nxt_r.state    = S_SRAM;
                  end
                  W_DRAM: begin
                     nxt_r.sel.dram = 1'b1;
                     nxt_r.open_bank = bank;
                     nxt_r.open_row  = CPU_ADDR[22:11];
                     // page hit goes straight to CAS
                     if (!p1_eff[HIT_DIS_BIT] && r_ff.page_open &&
                         r_ff.open_row == CPU_ADDR[22:11] && r_ff.open_bank == bank) begin
                        nxt_r.state = S_CAS;
                     end else if (!p1_eff[ILV_DIS_BIT] && r_ff.page_open &&
                                  r_ff.open_bank != bank) begin
                        nxt_r.ras_n = 2'b11;
                        nxt_r.state = S_RAS;
                     end else begin
                        nxt_r.ras_n = 2'b11;
                        nxt_r.state = S_PRE;
                     end
                  end
                  W_ERR: begin
                     // unassigned space answers with bus error
                     nxt_r.berr  = 1'b1;
                     nxt_r.ack   = 1'b1;
                  end
                  default: begin
                     // I/O device from address bits 15:8
                     io_dev = (dec_win == W_IO);
                     nxt_r.sel.rom  = (dec_win == W_ROM);
                     nxt_r.sel.ext  = (dec_win == W_EXT);
                     nxt_r.sel.uart = io_dev && CPU_ADDR[15:8] == IO_UART;
                     nxt_r.sel.pio  = io_dev && CPU_ADDR[15:8] == IO_PIO;
                     nxt_r.sel.led  = io_dev && CPU_ADDR[15:8] == IO_LED;
                     nxt_r.sel.host = io_dev && CPU_ADDR[15:8] == IO_HOST;
                     nxt_r.rd_n  = CPU_WR;
                     nxt_r.wr_n  = ~CPU_WR;
                     nxt_r.state = S_LOCAL;
                  end
               endcase
            end
         end
         S_SRAM: begin
            // read waits; writes finish at once
            if (r_ff.wr || r_ff.cnt[3:0] >= swait) begin
               nxt_r.state = S_DONE;
            end else begin
               nxt_r.cnt = r_ff.cnt + 9'h001;
            end
         end
         S_PRE: begin
            nxt_r.cnt = r_ff.cnt + 9'h001;
            if (r_ff.cnt[3:0] == dtim.pre - 4'h1) begin
               nxt_r.cnt   = 9'h000;
               nxt_r.state = S_RAS;
            end
         end
         S_RAS: begin
            // row held so RAS meets its minimum with CAS
            nxt_r.ras_n[r_ff.open_bank] = 1'b0;
            nxt_r.cnt = r_ff.cnt + 9'h001;
            if (r_ff.cnt[3:0] == dtim.ras - (r_ff.wr ? dtim.cas_wr : dtim.cas_rd) - 4'h1) begin
               nxt_r.cnt   = 9'h000;
               nxt_r.state = S_CAS;
            end
         end
         S_CAS: begin
            nxt_r.cas_n = 1'b0;
            nxt_r.cnt   = r_ff.cnt + 9'h001;
            if (r_ff.cnt[3:0] == (r_ff.wr ? dtim.cas_wr : dtim.cas_rd) - 4'h1) begin
               nxt_r.cas_n = 1'b1;
               // keep row open only when page hits are allowed
               nxt_r.page_open = ~p1_eff[HIT_DIS_BIT];
               if (p1_eff[HIT_DIS_BIT]) begin
                  nxt_r.ras_n = 2'b11;
               end
               nxt_r.state = S_DONE;
            end
         end
         S_LOCAL: begin
            nxt_r.cnt = r_ff.cnt + 9'h001;
            if (lb_tick) begin
               nxt_r.lbcnt = r_ff.lbcnt + 9'h001;
            end
            // device length but never below the programmed minimum
            need = (r_ff.win == W_ROM) ? ROM_LB_CYC : IO_LB_CYC;
            if (lwid_cyc > need || r_ff.win == W_EXT) begin
               need = lwid_cyc;
            end
            if (r_ff.cnt == TIMEOUT_CNT - 9'h001) begin
               // timeout ends the cycle; flag drops
               nxt_r.tof_n = 1'b0;
               nxt_r.state = S_DONE;
            end else if (r_ff.win != W_TO && r_ff.lbcnt >= need &&
                         (r_ff.win != W_EXT || EXT_READY)) begin
               nxt_r.state = S_DONE;
               if (r_ff.sel.pio) begin
                  // byte data on bits 7:0; port layouts
                  unique case (r_ff.addr[3:2])
                     PIO_LOCAL_TIMING_PORT: nxt_r.rdata = {2'b11, p0_eff[5:4], 4'hf};
                     PIO_MEMORY_TIMING_PORT: nxt_r.rdata = {2'b11, p1_eff[5:0]};
                     // DSR inverted; presence detect in 7:6
                     PIO_STATUS_CONTROL_PORT: nxt_r.rdata = {MODULE_PRESENCE_DETECT, r_ff.tof_n, ~DSR_IN,
                                               p2_eff[3:1], 1'b1};
                     PIO_CMD:   nxt_r.rdata = 8'hff;
                  endcase
                  if (r_ff.wr) begin
                     unique case (r_ff.addr[3:2])
                        PIO_LOCAL_TIMING_PORT: nxt_r.p0 = CPU_WDATA;
                        PIO_MEMORY_TIMING_PORT: nxt_r.p1 = CPU_WDATA;
                        PIO_STATUS_CONTROL_PORT: nxt_r.p2 = CPU_WDATA;
                        PIO_CMD: begin
                           if (CPU_WDATA[CMD_MODE_BIT]) begin
                              // Mode word sets port directions
                              nxt_r.dir = {~CPU_WDATA[CMD_P2_IN_BIT],
                                           ~CPU_WDATA[CMD_P1_IN_BIT],
                                           ~CPU_WDATA[CMD_P0_IN_BIT]};
                           end else begin
                              // Single-bit set or reset on port 2
                              nxt_r.p2[CPU_WDATA[3:1]] = CPU_WDATA[0];
                           end
                        end
                     endcase
                  end
               end
            end
         end
         S_DONE: begin
            nxt_r.ack   = 1'b1;
            nxt_r.sel   = '0;
            nxt_r.rd_n  = 1'b1;
            nxt_r.wr_n  = 1'b1;
            nxt_r.cas_n = 1'b1;
            nxt_r.cnt   = 9'h000;
            nxt_r.state = S_IDLE;
         end
         S_REF: begin
            // CAS low first, then RAS low, then release
            nxt_r.cnt = r_ff.cnt + 9'h001;
            if (r_ff.cnt[3:0] == 4'h0) begin
               nxt_r.ras_n = 2'b00;
            end else if (r_ff.cnt[3:0] == dtim.ras) begin
               nxt_r.ras_n = 2'b11;
               nxt_r.cas_n = 1'b1;
               nxt_r.cnt   = 9'h000;
               nxt_r.state = S_IDLE;
            end
         end
      endcase
      // gate blocks lines 0 to 2; line 0 also carries the timeout
      nxt_r.irq_n = p2_eff[GATE_BIT] ? 3'b111 :
                    {IRQ_IN_N[2:1], IRQ_IN_N[0] & r_ff.tof_n};
      // DTR pin is inverse of the control bit
      nxt_r.dtr = ~p2_eff[DTR_BIT];
   end

   // State register
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         r_ff          <= '0;
         r_ff.state    <= S_IDLE;
         r_ff.win      <= W_ERR;
         r_ff.ras_n    <= 2'b11;
         r_ff.cas_n    <= 1'b1;
         r_ff.rd_n     <= 1'b1;
         r_ff.wr_n     <= 1'b1;
         r_ff.p0       <= PORT_RST;
         r_ff.p1       <= PORT_RST;
         r_ff.p2       <= PORT_RST;
         r_ff.tof_n    <= 1'b1;
         r_ff.clr_prev <= 1'b1;
         r_ff.irq_n    <= 3'b111;
      end else begin
         r_ff <= nxt_r;
      end
   end

   // Outputs straight from the state register
   assign CPU_ACK         = r_ff.ack;
   assign CPU_BERR        = r_ff.berr;
   assign CPU_RDATA       = r_ff.rdata;
   assign SEL             = r_ff.sel;
   assign RAS_N           = r_ff.ras_n;
   assign CAS_N           = r_ff.cas_n;
   assign LB_RD_N         = r_ff.rd_n;
   assign LB_WR_N         = r_ff.wr_n;
   assign LOCAL_BUS_CLOCK = r_ff.local_bus_clock;
   assign IRQ_OUT_N       = r_ff.irq_n;
   assign DTR_OUT         = r_ff.dtr;

   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);

   timeout_window_a: assert property (
      r_ff.state == S_IDLE && !r_ff.ref_pend && CPU_REQ && dec_win == W_TO && !CPU_ACK
      |-> ##201 !r_ff.tof_n ##1 CPU_ACK) else $error("timeout not raised");
   sram_select_a: assert property (
      r_ff.state == S_IDLE && !r_ff.ref_pend && CPU_REQ && CPU_ADDR <= SRAM_TOP && !CPU_ACK
      |=> SEL.sram) else $error("sram not selected");
   bus_error_a: assert property (
      r_ff.state == S_IDLE && !r_ff.ref_pend && CPU_REQ && CPU_ADDR[31:24] == 8'h08 && !CPU_ACK
      |=> CPU_BERR && CPU_ACK) else $error("bus error missing");
   sram_write_a: assert property (
      r_ff.state == S_IDLE && !r_ff.ref_pend && CPU_REQ && CPU_WR && dec_win == W_SRAM && !CPU_ACK
      |=> ##2 CPU_ACK) else $error("sram write delayed");
   flag_sticky_a: assert property (
      !r_ff.tof_n && !(p2_eff[TCLR_BIT] && !r_ff.clr_prev) |=> !r_ff.tof_n)
      else $error("timeout flag lost");
   gate_block_a: assert property (
      p2_eff[GATE_BIT] |=> IRQ_OUT_N == 3'b111) else $error("interrupt not gated");
   dtr_invert_a: assert property (
      ##1 DTR_OUT == ~$past(p2_eff[DTR_BIT])) else $error("dtr not inverse");
   refresh_due_a: assert property (
      r_ff.ref_cnt == REFRESH_CNT - 9'h001 |=> r_ff.ref_pend)
      else $error("refresh not requested");
   local_bus_clock_half_a: assert property (
      tclk_rise |=> LOCAL_BUS_CLOCK != $past(LOCAL_BUS_CLOCK))
      else $error("local clock not toggled");

   rom_read_c: cover property (r_ff.state == S_LOCAL && r_ff.win == W_ROM ##[1:300] CPU_ACK);
   page_hit_c: cover property (r_ff.state == S_IDLE && nxt_r.state == S_CAS);
   timeout_c:  cover property ($fell(r_ff.tof_n));
   refresh_c:  cover property (r_ff.state == S_REF);
endmodule

// ---- hdl/board_bus_pkg.sv ----
// Constants, types and carriers shared by the board bus controller
package board_bus_pkg;
   // Clock and times
   localparam int CLK_MHZ       = 25;
   localparam int TIMEOUT_NS    = 8000;
   localparam int REFRESH_NS    = 13000;
   localparam int TIMEOUT_CYC   = (TIMEOUT_NS * CLK_MHZ + 999) / 1000;
   localparam int REFRESH_CYC   = (REFRESH_NS * CLK_MHZ) / 1000;
   localparam logic [8:0] TIMEOUT_CNT = 9'(TIMEOUT_CYC);
   localparam logic [8:0] REFRESH_CNT = 9'(REFRESH_CYC);
   // Physical windows, compared on address bits 31:24 or full address
   localparam logic [31:0] SRAM_TOP   = 32'h0007_ffff;
   localparam logic [7:0]  DRAM_LO    = 8'h04;
   localparam logic [7:0]  DRAM_HI    = 8'h07;
   localparam logic [7:0]  TO_LO      = 8'h10;
   localparam logic [7:0]  TO_HI      = 8'h15;
   localparam logic [7:0]  EXT_PAGE   = 8'h1a;
   localparam logic [7:0]  IO_PAGE    = 8'h1c;
   localparam logic [7:0]  ROM_PAGE   = 8'h1f;
   // I/O device codes on address bits 15:8
   localparam logic [7:0]  IO_UART    = 8'h00;
   localparam logic [7:0]  IO_PIO     = 8'h01;
   localparam logic [7:0]  IO_LED     = 8'h02;
   localparam logic [7:0]  IO_HOST    = 8'h03;
   // Port register index on address bits 3:2
   localparam logic [1:0]  PIO_LOCAL_TIMING_PORT  = 2'h0;
   localparam logic [1:0]  PIO_MEMORY_TIMING_PORT  = 2'h1;
   localparam logic [1:0]  PIO_STATUS_CONTROL_PORT  = 2'h2;
   localparam logic [1:0]  PIO_CMD    = 2'h3;
   // Port bit positions
   localparam int LWID_LSB = 4;
   localparam int SWAIT_LSB = 4;
   localparam int ILV_DIS_BIT = 3;
   localparam int HIT_DIS_BIT = 2;
   localparam int DWID_LSB = 0;
   localparam int DTR_BIT = 3;
   localparam int GATE_BIT = 2;
   localparam int TCLR_BIT = 1;
   localparam int CMD_MODE_BIT = 7;
   localparam int CMD_P0_IN_BIT = 4;
   localparam int CMD_P1_IN_BIT = 1;
   localparam int CMD_P2_IN_BIT = 0;
   localparam logic [7:0] PORT_RST = 8'hff;
   // Local bus device lengths in local bus clocks
   localparam logic [8:0] ROM_LB_CYC = 9'h004;
   localparam logic [8:0] IO_LB_CYC  = 9'h005;

   typedef enum logic [2:0] {W_SRAM, W_DRAM, W_EXT, W_IO, W_ROM, W_TO, W_ERR} win_e;

   typedef struct packed {
      logic sram;
      logic dram;
      logic rom;
      logic ext;
      logic uart;
      logic pio;
      logic led;
      logic host;
   } win_sel_s;

   typedef struct packed {
      logic [3:0] pre;
      logic [3:0] ras;
      logic [3:0] cas_rd;
      logic [3:0] cas_wr;
   } dram_tim_s;
endpackage

// ---- tb/cpu_bus_model.sv ----
// Processor system bus master model with its transmit clock
`timescale 1ns/1ps
module cpu_bus_model (
   // Clock and answers
   input  wire logic                clk,
   input  wire logic                ack,
   input  wire logic                berr,
   input  wire logic [7:0]          rdata,
   input  board_bus_pkg::win_sel_s  sel,
   // Requests
   output logic                     req,
   output logic [31:0]              addr,
   output logic                     wr,
   output logic                     half,
   output logic [7:0]               wdata,
   output logic                     tclk
);
   import board_bus_pkg::*;
   // Transmit clock, 160 ns period, well below half the reference rate
   initial begin
      tclk = 1'b0;
      forever #80 tclk = ~tclk;
   end
   // Idle bus at time zero
   initial begin
      req = 1'b0;
      {addr, wr, half, wdata} = '0;
   end
   // One request held until ack is sampled; lat counts edges with a window selected
   task automatic access(input logic [31:0] a, input logic w, input logic h,
                         input logic [7:0] d, output logic [7:0] q, output logic e,
                         output win_sel_s s, output int lat, output int tot);
      tot = 0;
      lat = 0;
      s = '0;
      @(negedge clk);
      req <= 1'b1;
      addr <= a;
      wr <= w;
      half <= h;
      wdata <= d;
      do begin
         @(posedge clk);
         tot++;
         s = s | sel;
         if (sel != '0) lat++;
      end while (ack !== 1'b1 && tot < 1000);
      q = rdata;
      e = berr;
      if (tot >= 1000) lat = -1;
      // Released address and data lines show the inverse, never the stale value
      @(negedge clk);
      req <= 1'b0;
      addr <= ~a;
      wdata <= ~d;
   endtask
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the board bus controller
`timescale 1ns/1ps
module testbench;
   import board_bus_pkg::*;
   logic        clk, rst_n, req, wr, half, ack, berr, ras_cas_n, lb_rd_n, lb_wr_n;
   logic        local_bus_clock, tclk, ext_ready, dtr_out, dsr_in, e;
   logic [31:0] addr;
   logic [7:0]  wdata, rdata, q;
   logic [2:0]  irq_in_n, irq_out_n;
   logic [1:0]  ras_n, pd;
   win_sel_s    sel, s;
   int          mismatches, n_compared, lat, tot, cyc, tc, lb;
   int          lr[4], ld[4];
   // Clock, 40 ns period
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   cpu_bus_model cpu (.clk(clk), .ack(ack), .berr(berr), .rdata(rdata), .sel(sel),
      .req(req), .addr(addr), .wr(wr), .half(half), .wdata(wdata), .tclk(tclk));
   board_bus_controller DUT (.REF_CLK(clk), .RST_N(rst_n), .CPU_REQ(req), .CPU_ADDR(addr),
      .CPU_WR(wr), .CPU_HALF(half), .CPU_WDATA(wdata), .CPU_ACK(ack), .CPU_BERR(berr),
      .CPU_RDATA(rdata), .SEL(sel), .RAS_N(ras_n), .CAS_N(ras_cas_n), .LB_RD_N(lb_rd_n),
      .LB_WR_N(lb_wr_n), .LOCAL_BUS_CLOCK(local_bus_clock), .PROCESSOR_TRANSMIT_CLOCK(tclk),
      .EXT_READY(ext_ready), .IRQ_IN_N(irq_in_n), .IRQ_OUT_N(irq_out_n),
      .DTR_OUT(dtr_out), .DSR_IN(dsr_in), .MODULE_PRESENCE_DETECT(pd));
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
      n_compared++;
      if ((got & m) !== (exp & m)) begin
         mismatches++;
         $display("[FAIL] %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_n(input int got, input int exp);
      n_compared++;
      if (got != exp) begin
         mismatches++;
         $display("[FAIL] %0t count %0d expected %0d", $time, got, exp);
      end
   endtask
   task automatic close_out();
      $display("compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic go(input logic [31:0] a, input logic w, input logic h, input logic [7:0] d);
      cpu.access(a, w, h, d, q, e, s, lat, tot);
      // A missing acknowledge counts against the run
      if (tot >= 1000) begin
         mismatches++;
         $display("[FAIL] %0t no acknowledge", $time);
      end
   endtask
   // Port access; big-endian byte offset in the low bits
   task automatic port(input logic [1:0] i, input logic w, input logic [7:0] d);
      go(32'h1c00_0103 | {28'h0, i, 2'b00}, w, 1'b0, d);
   endtask
   // Run guard, far above the expected few thousand cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         $display("[FAIL] %0t run guard expired", $time);
         close_out();
      end
   end
   always @(posedge tclk) if (rst_n) tc++;
   always @(posedge local_bus_clock) if (rst_n) lb++;
   localparam logic [31:0] WADR[7] = '{32'h0007_fff0, 32'h0400_0000, 32'h1f00_0000,
      32'h1a00_0000, 32'h1c00_0000, 32'h1c00_0200, 32'h1c00_0300};
   localparam logic [7:0] WSEL[7] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h02, 8'h01};
   localparam logic [31:0] EADR[3] = '{32'h0800_0000, 32'h0008_0000, 32'h1600_0000};
   localparam int DSUM[4] = '{5, 7, 9, 11};
   initial begin
      {mismatches, n_compared, cyc, tc, lb} = '0;
      {rst_n, ext_ready, dsr_in, pd, irq_in_n} = {1'b0, 1'b1, 1'b1, 2'b10, 3'b000};
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      // Reset levels; gate holds the sources off
      port(2'h0, 1'b0, 8'h00);
      cmp(q, 8'hff, 8'hff);
      port(2'h1, 1'b0, 8'h00);
      cmp(q, 8'hff, 8'hff);
      port(2'h2, 1'b0, 8'h00);
      cmp(q, 8'haf, 8'hff);
      cmp({dtr_out, irq_out_n}, 4'h7, 8'h0f);
      $display("reset test done");
      for (int i = 0; i < 7; i++) begin
         go(WADR[i], 1'b0, 1'b1, 8'h00);
         cmp({s}, WSEL[i], 8'hff);
         cmp({7'h0, e}, 8'h00, 8'h01);
      end
      for (int i = 0; i < 4; i++) begin
         go((i == 3) ? 32'h1a00_0000 : EADR[i], 1'b0, 1'b0, 8'h00);
         cmp(s, 8'h00, 8'hff);
         cmp({7'h0, e}, 8'h01, 8'h01);
      end
      $display("decode test done");
      port(2'h3, 1'b1, 8'h80);
      port(2'h2, 1'b1, 8'h02);
      @(negedge clk) irq_in_n = 3'b010;
      @(negedge clk);
      cmp({dtr_out, irq_out_n}, 4'ha, 8'h0f);
      for (int i = 0; i < 4; i++) begin
         port(2'h1, 1'b1, {2'b00, 2'(i), 4'hf});
         go(32'h0000_0100, 1'b0, 1'b0, 8'h00);
         lr[i] = lat;
         cmp_n(lr[i] - lr[0], i);
         go(32'h0000_0100, 1'b1, 1'b0, 8'h5a);
         cmp_n(lat, lr[0]);
         port(2'h1, 1'b1, {4'h0, 2'b11, 2'(i)});
         go(32'h0400_0000, 1'b0, 1'b0, 8'h00);
         go(32'h0400_0000, 1'b0, 1'b0, 8'h00);
         ld[i] = lat;
         cmp({6'h0, ras_n}, 8'h03, 8'h03);
         cmp_n(ld[i] - ld[0], DSUM[i] - 5);
      end
      // Two tries each: a refresh between accesses may close the open row
      port(2'h1, 1'b1, 8'h0b);
      go(32'h0400_0010, 1'b0, 1'b0, 8'h00);
      go(32'h0400_0010, 1'b0, 1'b0, 8'h00);
      lr[1] = lat;
      go(32'h0400_0010, 1'b0, 1'b0, 8'h00);
      cmp_n(ld[3] - ((lat < lr[1]) ? lat : lr[1]), 7);
      port(2'h1, 1'b1, 8'h03);
      go(32'h0400_0000, 1'b0, 1'b0, 8'h00);
      go(32'h0400_0008, 1'b0, 1'b0, 8'h00);
      lr[1] = lat;
      go(32'h0400_0000, 1'b0, 1'b0, 8'h00);
      cmp_n(ld[3] - ((lat < lr[1]) ? lat : lr[1]), 5);
      // Expansion cycle of 4 against 1 local clock; clock phase adds up to 7
      port(2'h0, 1'b1, 8'h1f);
      go(32'h1a00_0000, 1'b0, 1'b1, 8'h00);
      lr[2] = lat;
      port(2'h0, 1'b1, 8'h0f);
      go(32'h1a00_0000, 1'b0, 1'b1, 8'h00);
      cmp_n(int'(lat - lr[2] >= 17 && lat - lr[2] <= 31), 1);
      $display("timing test done");
      irq_in_n = 3'b111;
      go(32'h1000_0000, 1'b0, 1'b0, 8'h00);
      cmp_n(int'(tot >= 200 && tot <= 215 && e === 1'b0), 1);
      cmp({5'h0, irq_out_n}, 8'h06, 8'h07);
      port(2'h2, 1'b1, 8'h00);
      port(2'h2, 1'b0, 8'h00);
      cmp(q, 8'h00, 8'h20);
      port(2'h2, 1'b1, 8'h02);
      port(2'h2, 1'b0, 8'h00);
      cmp({q[5], irq_out_n}, 4'hf, 8'h0f);
      $display("timeout test done");
      cmp_n(int'(tc - 2 * lb <= 2 && 2 * lb - tc <= 2), 1);
      close_out();
   end
endmodule
